// ==== dcit_regs.svh ====
// register offsets, field positions and reset values of the interval timer
// assumes an avalon-mm slave with word-aligned byte addresses
`ifndef DCIT_REGS_SVH
`define DCIT_REGS_SVH
`define DCIT_OFS_MODE 4'h0
`define DCIT_OFS_PINC 4'h1
`define DCIT_OFS_COUNT 4'h2
`define DCIT_OFS_RUNC 4'h3
`define DCIT_OFS_CLKEN 4'h4
`define DCIT_OFS_STAT 4'h5
`define DCIT_OFS_CLR 4'h6
`define DCIT_OFS_IEN 4'h7
`define DCIT_MODE_LSB 0
`define DCIT_SRC_LSB 4
`define DCIT_EDGPL_BIT 3
`define DCIT_POL_BIT 0
`define DCIT_OEN_BIT 2
`define DCIT_FILT_LSB 4
`define DCIT_GATE_LSB 6
`define DCIT_START_BIT 0
`define DCIT_RUNF_BIT 1
`define DCIT_STOP_BIT 2
`define DCIT_UNDF_BIT 5
`define DCIT_MODE_RST 8'h00
`define DCIT_PINC_RST 8'h00
`define DCIT_COUNT_RST 16'hffff
`define DCIT_DIV8 5'h07
`define DCIT_DIV2 5'h01
`define DCIT_DIV32 5'h1f
`endif

// ==== dcit_pkg.sv ====
// types of the down-counting interval timer
// assumes dcit_regs.svh supplies the numeric constants
package dcit_pkg;
   typedef enum logic [2:0]
   {
      dcit_src_sys = 3'h0,
      dcit_src_div8 = 3'h1,
      dcit_src_div2 = 3'h3,
      dcit_src_low = 3'h4,
      dcit_src_link = 3'h5,
      dcit_src_sub = 3'h6
   } dcit_src_t;
   typedef enum logic [2:0]
   {
      dcit_md_timer = 3'h0,
      dcit_md_pulse = 3'h1,
      dcit_md_event = 3'h2,
      dcit_md_width = 3'h3,
      dcit_md_period = 3'h4
   } dcit_mode_t;
endpackage : dcit_pkg

// ==== dcit_timer.sv ====
// down-counting interval timer with avalon-mm register slave
// assumes all pin inputs asynchronous to i_clk; one clock domain
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "dcit_regs.svh"
module dcit_timer
   import dcit_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_timer_io_pin,
   input wire logic i_low_clk_tick,
   input wire logic i_sub_clk_tick,
   input wire logic i_event_link,
   input wire logic i_gate_irq_pin,
   output logic o_timer_io_pin,
   output logic o_timer_io_pin_oe,
   output logic o_timer_out_pin,
   output logic o_timer_out_pin_oe,
   output logic o_timer_interrupt
);
   logic [7:0] mode_reg, mode_next;
   logic [7:0] pinc_reg, pinc_next;
   logic [15:0] reload_reg, reload_next;
   logic [15:0] cnt_reg, cnt_next;
   logic run_reg, run_next;
   logic undf_reg, undf_next;
   logic clken_reg, clken_next;
   logic stat_reg, stat_next;
   logic ien_reg, ien_next;
   logic lvl_reg, lvl_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   logic irq_reg, irq_next;
   logic [4:0] pre_reg, pre_next;
   logic [4:0] fdiv_reg, fdiv_next;
   logic [1:0] sync_reg, sync_next;
   logic [1:0] gsync_reg, gsync_next;
   logic [2:0] flt_reg, flt_next;
   logic fin_reg, fin_next;
   logic tick;
   logic evt;
   logic gate_ok;
   logic fs;
   logic uf;
   logic wr, rd;
   dcit_mode_t md;
   dcit_src_t src;

   // word index of an avalon byte address
   function automatic logic [3:0] widx(input logic [4:0] a);
      widx = a[4:2] == 3'h0 ? 4'h0 : {1'b0, a[4:2]};
   endfunction : widx

   // divider strobe: every masked bit of the free-running count is set
   function automatic logic rate_hit(input logic [4:0] c,
                                     input logic [4:0] m);
      rate_hit = (c & m) == m;
   endfunction : rate_hit

   assign md = dcit_mode_t'(mode_reg[`DCIT_MODE_LSB +: 3]);
   assign src = dcit_src_t'(mode_reg[`DCIT_SRC_LSB +: 3]);
   // writes land at the answer edge; reads are captured at the taking edge
   // so that the read word already stands when waitrequest is seen low
   assign wr = i_avs_write & ~wait_reg;
   assign rd = i_avs_read & wait_reg;

   // prescaler and filter divider free-run only while the gate is on
   always_comb
   begin
      pre_next = clken_reg ? pre_reg + 5'h01 : 5'h00;
      fdiv_next = clken_reg ? fdiv_reg + 5'h01 : 5'h00;
      unique case (src)
         dcit_src_sys: tick = 1'b1;
         dcit_src_div8: tick = rate_hit(pre_reg, `DCIT_DIV8);
         dcit_src_div2: tick = rate_hit(pre_reg, `DCIT_DIV2);
         dcit_src_low: tick = i_low_clk_tick;
         dcit_src_link: tick = i_event_link;
         dcit_src_sub: tick = i_sub_clk_tick;
         default: tick = 1'b0;
      endcase
   end

   // io pin: two-flop synchroniser, then optional filter that changes only when three samples agree
   always_comb
   begin
      sync_next = {sync_reg[0], i_timer_io_pin};
      gsync_next = {gsync_reg[0], i_gate_irq_pin};
      unique case (pinc_reg[`DCIT_FILT_LSB +: 2])
         2'h1: fs = 1'b1;
         2'h2: fs = rate_hit(fdiv_reg, `DCIT_DIV8);
         2'h3: fs = fdiv_reg == `DCIT_DIV32;
         default: fs = 1'b0;
      endcase
      flt_next = fs ? {flt_reg[1:0], sync_reg[1]} : flt_reg;
      if (pinc_reg[`DCIT_FILT_LSB +: 2] == 2'h0)
         fin_next = sync_reg[1];
      else if (flt_reg == 3'h7)
         fin_next = 1'b1;
      else if (flt_reg == 3'h0)
         fin_next = 1'b0;
      else
         fin_next = fin_reg;
   end

   // qualified event edge and its gate
   always_comb
   begin
      unique case (pinc_reg[`DCIT_GATE_LSB +: 2])
         2'h0: gate_ok = 1'b1;
         2'h1: gate_ok = gsync_reg[1] ^ mode_reg[`DCIT_EDGPL_BIT];
         2'h2: gate_ok = lvl_reg ^ mode_reg[`DCIT_EDGPL_BIT];
         default: gate_ok = 1'b0;
      endcase
      // rising edge, or falling with the polarity bit set
      evt = gate_ok & (pinc_reg[`DCIT_POL_BIT] ? (fin_reg & ~fin_next)
                                               : (~fin_reg & fin_next));
   end

   // counter, flags and register writes
   always_comb
   begin
      mode_next = mode_reg;
      pinc_next = pinc_reg;
      reload_next = reload_reg;
      cnt_next = cnt_reg;
      run_next = run_reg;
      undf_next = undf_reg;
      clken_next = clken_reg;
      stat_next = stat_reg;
      ien_next = ien_reg;
      lvl_next = lvl_reg;
      uf = 1'b0;
      if (run_reg && (md == dcit_md_event ? evt : tick))
      begin
         if (cnt_reg == 16'h0000)
         begin
            uf = 1'b1;
            cnt_next = reload_reg;
         end
         else
            cnt_next = cnt_reg - 16'h0001;
      end
      if (uf && (md == dcit_md_pulse || md == dcit_md_event))
         lvl_next = ~lvl_reg;
      if (!run_reg && md == dcit_md_pulse)
         lvl_next = ~pinc_reg[`DCIT_POL_BIT];
      if (wr && widx(i_avs_address) == `DCIT_OFS_CLKEN && i_avs_byteenable[0])
         clken_next = i_avs_writedata[0];
      if (wr && clken_reg && i_avs_byteenable[0])
      begin
         unique case (widx(i_avs_address))
            `DCIT_OFS_MODE: mode_next = {1'b0, i_avs_writedata[6:0]};
            `DCIT_OFS_PINC: pinc_next = i_avs_writedata[7:0] & 8'hf5;
            `DCIT_OFS_COUNT:
            begin
               reload_next[7:0] = i_avs_writedata[7:0];
               if (!run_reg)
                  cnt_next[7:0] = i_avs_writedata[7:0];
            end
            `DCIT_OFS_RUNC:
            begin
               run_next = i_avs_writedata[`DCIT_START_BIT];
               if (i_avs_writedata[`DCIT_STOP_BIT])
                  run_next = 1'b0;
               if (!i_avs_writedata[`DCIT_UNDF_BIT])
                  undf_next = 1'b0;
            end
            `DCIT_OFS_CLR:
               if (i_avs_writedata[0])
                  stat_next = 1'b0;
            `DCIT_OFS_IEN: ien_next = i_avs_writedata[0];
            default: ;
         endcase
      end
      if (wr && clken_reg && i_avs_byteenable[1]
          && widx(i_avs_address) == `DCIT_OFS_COUNT)
      begin
         reload_next[15:8] = i_avs_writedata[15:8];
         if (!run_reg)
            cnt_next[15:8] = i_avs_writedata[15:8];
      end
      // set wins over a clear in the same cycle
      if (uf)
      begin
         undf_next = 1'b1;
         stat_next = 1'b1;
      end
   end

   // answer, readback and outputs
   always_comb
   begin
      wait_next = ~((i_avs_read | i_avs_write) & wait_reg);
      rdata_next = rdata_reg;
      if (rd)
      begin
         unique case (widx(i_avs_address))
            `DCIT_OFS_MODE: rdata_next = {24'h0, mode_reg};
            `DCIT_OFS_PINC: rdata_next = {24'h0, pinc_reg};
            `DCIT_OFS_COUNT: rdata_next = {16'h0, cnt_reg};
            `DCIT_OFS_RUNC: rdata_next = {26'h0, undf_reg, 3'h0, run_reg,
                                          run_reg};
            `DCIT_OFS_CLKEN: rdata_next = {31'h0, clken_reg};
            `DCIT_OFS_STAT: rdata_next = {31'h0, stat_reg};
            `DCIT_OFS_IEN: rdata_next = {31'h0, ien_reg};
            default: rdata_next = 32'h0;
         endcase
      end
      irq_next = stat_next & ien_next;
   end

   // bus answer and clock gate
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         clken_reg <= 1'b0;
         rdata_reg <= 32'h0;
         wait_reg <= 1'b1;
      end
      else
      begin
         clken_reg <= clken_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
      end
   end

   // pin synchronisers keep running so the pins settle before the gate opens
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sync_reg <= 2'h0;
         gsync_reg <= 2'h0;
      end
      else
      begin
         sync_reg <= sync_next;
         gsync_reg <= gsync_next;
      end
   end

   // timer state is held in reset while the clock gate is off
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mode_reg <= `DCIT_MODE_RST;
         pinc_reg <= `DCIT_PINC_RST;
         reload_reg <= `DCIT_COUNT_RST;
         cnt_reg <= `DCIT_COUNT_RST;
         run_reg <= 1'b0;
         undf_reg <= 1'b0;
         lvl_reg <= 1'b1;
      end
      else if (!clken_reg)
      begin
         mode_reg <= `DCIT_MODE_RST;
         pinc_reg <= `DCIT_PINC_RST;
         reload_reg <= `DCIT_COUNT_RST;
         cnt_reg <= `DCIT_COUNT_RST;
         run_reg <= 1'b0;
         undf_reg <= 1'b0;
         lvl_reg <= 1'b1;
      end
      else
      begin
         mode_reg <= mode_next;
         pinc_reg <= pinc_next;
         reload_reg <= reload_next;
         cnt_reg <= cnt_next;
         run_reg <= run_next;
         undf_reg <= undf_next;
         lvl_reg <= lvl_next;
      end
   end

   // interrupt status, enable and request, cleared with the timer state
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         stat_reg <= 1'b0;
         ien_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else if (!clken_reg)
      begin
         stat_reg <= 1'b0;
         ien_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         ien_reg <= ien_next;
         irq_reg <= irq_next;
      end
   end

   // prescaler, filter divider and filter, also held while gated off
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pre_reg <= 5'h00;
         fdiv_reg <= 5'h00;
         flt_reg <= 3'h0;
         fin_reg <= 1'b0;
      end
      else if (!clken_reg)
      begin
         pre_reg <= 5'h00;
         fdiv_reg <= 5'h00;
         flt_reg <= 3'h0;
         fin_reg <= 1'b0;
      end
      else
      begin
         pre_reg <= pre_next;
         fdiv_reg <= fdiv_next;
         flt_reg <= flt_next;
         fin_reg <= fin_next;
      end
   end

   logic out_reg, out_oe_reg, io_reg, io_oe_reg;
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         out_reg <= 1'b0;
         out_oe_reg <= 1'b0;
         io_reg <= 1'b0;
         io_oe_reg <= 1'b0;
      end
      else
      begin
         out_reg <= lvl_next;
         out_oe_reg <= clken_next & pinc_next[`DCIT_OEN_BIT];
         io_reg <= lvl_next;
         io_oe_reg <= clken_next
                      && mode_next[`DCIT_MODE_LSB +: 3] == dcit_md_pulse;
      end
   end

   assign o_timer_out_pin = out_reg;
   assign o_timer_out_pin_oe = out_oe_reg;
   assign o_timer_io_pin = io_reg;
   assign o_timer_io_pin_oe = io_oe_reg;
   assign o_timer_interrupt = irq_reg;
   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
endmodule : dcit_timer

// ==== dcit_timer_monitor.sv ====
// checker of the interval timer bus handshake and pin behaviour
// assumes the port list of dcit_timer; bound to it below
`timescale 1ns/10ps
module dcit_timer_monitor
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_timer_io_pin_oe,
   input wire logic o_timer_out_pin_oe,
   input wire logic o_timer_interrupt
);
   logic gate_reg;
   logic oen_reg;
   logic [1:0] off_reg;
   wire logic wr_acc = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
   wire logic [2:0] idx = i_avs_address[4:2];
   // shadow of clock gate and output enable, plus cycles since gate off
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         gate_reg <= 1'b0;
         oen_reg <= 1'b0;
         off_reg <= 2'h0;
      end
      else
      begin
         if (wr_acc && idx == 3'h4)
            gate_reg <= i_avs_writedata[0];
         if (!gate_reg)
            oen_reg <= 1'b0;
         else if (wr_acc && idx == 3'h1)
            oen_reg <= i_avs_writedata[2];
         off_reg <= gate_reg ? 2'h0 : off_reg + {1'b0, off_reg != 2'h3};
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_ANSWER: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("request not answered in the next cycle");
   AST_NO_SPUR: assert property (!i_avs_read && !i_avs_write |=>
      o_avs_waitrequest) else $error("answer without a request");
   AST_RDATA_HOLD: assert property (!$stable(o_avs_readdata) |->
      !o_avs_waitrequest && i_avs_read) else $error("readdata moved");
   AST_OEN: assert property (wr_acc && idx == 3'h1 && gate_reg |->
      ##[1:3] (o_timer_out_pin_oe == oen_reg))
      else $error("output enable does not follow its bit");
   AST_GATE_OFF: assert property (off_reg == 2'h3 |->
      !o_timer_out_pin_oe && !o_timer_io_pin_oe && !o_timer_interrupt)
      else $error("timer active while its clock gate is off");
   AST_MASK: assert property (wr_acc && idx == 3'h7 && gate_reg &&
      !i_avs_writedata[0] |-> ##[1:3] !o_timer_interrupt)
      else $error("interrupt not blocked");
   AST_STICKY: assert property ($fell(o_timer_interrupt) |->
      $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3))
      else $error("interrupt dropped without a register write");
endmodule : dcit_timer_monitor
bind dcit_timer dcit_timer_monitor u_mon (.i_clk, .i_reset_n, .i_avs_address,
   .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
   .o_avs_readdata, .o_avs_waitrequest, .o_timer_io_pin_oe,
   .o_timer_out_pin_oe, .o_timer_interrupt);

// ==== dcit_partner.sv ====
// model of the external event source and the gate interrupt pin
// assumes the bench calls one task at a time
`timescale 1ns/10ps
module dcit_partner
(
   input wire logic i_clk,
   output logic o_event_pin,
   output logic o_gate_pin
);
   initial
   begin
      o_event_pin = 1'b0;
      o_gate_pin = 1'b0;
   end
   task send_events(input int n, input int w);
      repeat (n)
      begin
         @(posedge i_clk);
         o_event_pin <= 1'b1;
         repeat (w) @(posedge i_clk);
         o_event_pin <= 1'b0;
         repeat (w) @(posedge i_clk);
      end
   endtask : send_events
   task set_gate(input logic v);
      @(posedge i_clk);
      o_gate_pin <= v;
   endtask : set_gate
endmodule : dcit_partner

// ==== dcit_timer_tb_top.sv ====
// self-checking bench of the down-counting interval timer
// assumes dcit_partner drives the event and gate pins
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
   err_count++; $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module dcit_timer_tb_top
   import dcit_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic tick = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rdata_q;
   logic wait_rq, io_out, io_oe, out_pin, out_oe, irq, ev_pin, gate_pin, ov;
   wire logic io_wire = io_oe ? io_out : ev_pin;
   int err_count = 0;
   int num_checks = 0;
   int tick_cnt = 0;
   int n, p;
   integer seed = 32'h9921950e;
   dcit_src_t srcs [6] = '{dcit_src_sys, dcit_src_div8, dcit_src_div2,
      dcit_src_low, dcit_src_link, dcit_src_sub};
   int divs [6] = '{1, 8, 2, 5, 5, 5};
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
      tick <= (tick_cnt == 4);
   end
   dcit_timer u_dut (.i_clk(clk), .i_reset_n(reset_n), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_rq), .i_timer_io_pin(io_wire),
      .i_low_clk_tick(tick), .i_sub_clk_tick(tick), .i_event_link(tick),
      .i_gate_irq_pin(gate_pin), .o_timer_io_pin(io_out),
      .o_timer_io_pin_oe(io_oe), .o_timer_out_pin(out_pin),
      .o_timer_out_pin_oe(out_oe), .o_timer_interrupt(irq));
   dcit_partner u_src (.i_clk(clk), .o_event_pin(ev_pin),
      .o_gate_pin(gate_pin));
   task wrap_up;
      if (err_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   function int exp_period(int div, int setting);
      return div * (setting + 1);
   endfunction : exp_period
   task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      addr <= {a, 2'b00};
      wdata <= d;
      wr <= w;
      rd <= ~w;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wait_rq !== 1'b0 && k < 50);
      rdata_q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k >= 50)
      begin
         err_count++;
         wrap_up();
      end
   endtask : bus
   // waits for one io pin toggle, then counts edges to the next
   task gap(output int q);
      logic v;
      q = 0;
      v = io_out;
      while (io_out === v && q < 200)
      begin
         @(posedge clk);
         q++;
      end
      v = io_out;
      q = 0;
      while (io_out === v && q < 200)
      begin
         @(posedge clk);
         q++;
      end
   endtask : gap
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      bus(1, 3'h0, 32'h1);
      bus(0, 3'h0, 32'h0);
      `CHK("write with gate off", 32'h0, rdata_q)
      bus(1, 3'h4, 32'h1);
      bus(0, 3'h2, 32'h0);
      `CHK("count reset", 32'hffff, rdata_q)
      for (int m = 0; m < 5; m++)
      begin
         bus(1, 3'h0, {25'h0, 3'h0, 1'b0, m[2:0]});
         bus(0, 3'h0, 32'h0);
         `CHK("mode", m[2:0], rdata_q[2:0])
      end
      for (int i = 0; i < 6; i++)
      begin
         n = (i == 0) ? 0 : ($random(seed) & 7);
         bus(1, 3'h3, 32'h0);
         bus(1, 3'h0, {25'h0, srcs[i], 1'b0, dcit_md_pulse});
         bus(1, 3'h1, {29'h0, 2'b10, i[0]});
         bus(1, 3'h2, n);
         `CHK("start level", ~i[0], io_out)
         `CHK("io oe", 1'b1, io_oe)
         bus(1, 3'h6, 32'h1);
         bus(1, 3'h7, 32'h1);
         bus(1, 3'h3, 32'h1);
         gap(p);
         `CHK("period", exp_period(divs[i], n), p)
         `CHK("irq", 1'b1, irq)
         bus(1, 3'h6, 32'h1);
         bus(1, 3'h7, 32'h0);
         repeat (2) @(posedge clk);
         `CHK("irq masked", 1'b0, irq)
      end
      bus(1, 3'h0, {25'h0, dcit_src_sys, 1'b0, dcit_md_timer});
      bus(1, 3'h3, 32'h0);
      bus(1, 3'h2, 32'hc8);
      repeat (5) @(posedge clk);
      bus(0, 3'h2, 32'h0);
      `CHK("stopped count", 32'hc8, rdata_q)
      bus(1, 3'h3, 32'h1);
      bus(0, 3'h2, 32'h0);
      `CHK("counting", 1'b1, rdata_q[15:0] < 16'hc8)
      bus(0, 3'h3, 32'h0);
      `CHK("running flag", 1'b1, rdata_q[1])
      bus(1, 3'h3, 32'h0);
      bus(1, 3'h0, {25'h0, dcit_src_sys, 1'b0, dcit_md_event});
      for (int f = 0; f < 5; f++)
      begin
         bus(1, 3'h1, (f < 4) ? {24'h0, 2'b00, f[1:0], 4'h4} : 32'h44);
         bus(1, 3'h2, 32'h2);
         bus(1, 3'h3, 32'h1);
         ov = out_pin;
         u_src.set_gate(1'b0);
         if (f > 0 && f < 4)
            u_src.send_events(3, 2);
         u_src.send_events(3, 120);
         if (f == 4)
         begin
            u_src.set_gate(1'b1);
            u_src.send_events(3, 120);
         end
         `CHK("event toggle", ~ov, out_pin)
         bus(1, 3'h3, 32'h0);
      end
      bus(1, 3'h4, 32'h0);
      repeat (4) @(posedge clk);
      `CHK("gate off", 3'h0, {out_oe, io_oe, irq})
      wrap_up();
   end
endmodule : dcit_timer_tb_top
